// ===== core/tpm_defs.vh
// How it works
// R01 - single pwm, pol 0: low idle, match high
// R02 - single pwm, pol 1: high idle, match low
// R03 - capture on rising (0) or falling (1)
// R04 - compare disabled: output equals polarity bit
// R05 - compare enabled: output toggles on reload
// R06 - gated pol 0: count high, irq falling
// R07 - gated pol 1: count low, irq rising
// R08 - capcmp pol 0: start rising, capture later rising
// R09 - capcmp pol 1: start falling, capture later falling
// R10 - dual pwm pol 0: out low/comp high idle
// R11 - dual pwm pol 1: out high/comp low idle
// R12 - dual pwm: deadband delay before active level
// R13 - input synchronised, edges from successive samples
`ifndef TPM_DEFS_VH
`define TPM_DEFS_VH
// ****************************************
// register word addresses
// ****************************************
`define TPM_ADDR_CTRL 4'h0
`define TPM_ADDR_RELOAD 4'h1
`define TPM_ADDR_MATCH 4'h2
`define TPM_ADDR_COUNT 4'h3
`define TPM_ADDR_CAPTURE 4'h4
`define TPM_ADDR_STATUS 4'h5
`define TPM_ADDR_MASK 4'h6
`define TPM_ADDR_PINS 4'h7
// ****************************************
// control fields
// ****************************************
`define TPM_CTRL_EN 0
`define TPM_CTRL_POL 1
`define TPM_CTRL_MODE_LO 2
`define TPM_CTRL_MODE_HI 4
`define TPM_CTRL_DLY_LO 8
`define TPM_CTRL_DLY_HI 15
// ****************************************
// modes
// ****************************************
`define TPM_MODE_PWM1 3'h0
`define TPM_MODE_CAPT 3'h1
`define TPM_MODE_CMP 3'h2
`define TPM_MODE_GATED 3'h3
`define TPM_MODE_CAPCMP 3'h4
`define TPM_MODE_PWM2 3'h5
// ****************************************
// status bits and reset values
// ****************************************
`define TPM_ST_RELOAD 0
`define TPM_ST_CAPT 1
`define TPM_ST_GATE 2
`define TPM_ST_MATCH 3
`define TPM_CTRL_RST 32'h00000000
`define TPM_RELOAD_RST 16'hFFFF
`endif

// ===== core/tpm_sync.v
`timescale 1ns/10ps
// ****************************************
// two-stage synchroniser with edge detect
// ****************************************
module tpm_sync (
  input wire ref_clk, // system clock
  input wire reset_n, // sync reset, low
  input wire pin_in, // asynchronous pin
  output reg level, // synchronised level
  output wire rise, // one-cycle rising pulse
  output wire fall // one-cycle falling pulse
);
  reg meta;
  reg last;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      meta <= 1'b0;
      level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_in;
      level <= meta; // see R13
      last <= level;
    end
  end
  // edges compare successive synced samples only
  assign rise = level & ~last; // see R13
  assign fall = ~level & last; // see R13
endmodule

// ===== core/tpm_delay.v
`timescale 1ns/10ps
// ****************************************
// deadband delay before an active level
// ****************************************
module tpm_delay #(
  parameter W = 8 // width of delay count
) (
  input wire ref_clk, // system clock
  input wire reset_n, // sync reset, low
  input wire req, // wanted level is active
  input wire [W-1:0] delay, // cycles to wait
  output reg active // delayed active level
);
  reg [W-1:0] cnt;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt <= {W{1'b0}};
      active <= 1'b0;
    end else if (!req) begin
      cnt <= {W{1'b0}};
      active <= 1'b0;
    end else if (cnt >= delay) begin
      active <= 1'b1; // see R12
    end else begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== core/tpm_top.v
`timescale 1ns/10ps
`include "tpm_defs.vh"
module tpm_top (
  input wire ref_clk, // 200 MHz system clock
  input wire reset_n, // sync reset, low
  input wire [3:0] avs_address, // word address
  input wire avs_read, // read strobe
  input wire avs_write, // write strobe
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes
  output reg [31:0] avs_readdata, // read data
  output reg avs_waitrequest, // stall
  input wire timer_in, // timer input pin
  output reg timer_out, // timer output pin
  output reg timer_out_n, // complement output pin
  output reg irq // level interrupt
);
  // ****************************************
  // registers
  // ****************************************
  reg [31:0] timer_control_zero;
  reg [15:0] reload_val;
  reg [15:0] match_val;
  reg [15:0] count;
  reg [15:0] capture_val;
  reg [3:0] status;
  reg [3:0] mask;
  reg out_lvl;
  reg started;
  reg acked;
  wire en = timer_control_zero[`TPM_CTRL_EN];
  wire pol = timer_control_zero[`TPM_CTRL_POL];
  wire [2:0] mode =
    timer_control_zero[`TPM_CTRL_MODE_HI:`TPM_CTRL_MODE_LO];
  wire [7:0] pwm_deadband_delay =
    timer_control_zero[`TPM_CTRL_DLY_HI:`TPM_CTRL_DLY_LO];
  // ****************************************
  // input conditioning
  // ****************************************
  wire in_lvl;
  wire in_rise;
  wire in_fall;
  tpm_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(timer_in),
    .level(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );
  // polarity picks the active edge and level
  wire act_edge = pol ? in_fall : in_rise; // see R03
  wire gate_on = pol ? ~in_lvl : in_lvl; // see R06
  wire gate_end = pol ? in_rise : in_fall; // see R07
  // ****************************************
  // counter
  // ****************************************
  reg run;
  always @* begin
    case (mode)
      `TPM_MODE_GATED: run = en & gate_on; // see R06
      `TPM_MODE_CAPCMP: run = en & (started | act_edge); // see R08
      default: run = en;
    endcase
  end
  wire at_reload = run & (count == reload_val);
  wire at_match = run & (count == match_val);
  wire cap_now = en & act_edge &
    ((mode == `TPM_MODE_CAPT) |
     ((mode == `TPM_MODE_CAPCMP) & started)); // see R09
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      count <= 16'h0001;
      started <= 1'b0;
      capture_val <= 16'h0000;
    end else begin
      if (!en) begin
        started <= 1'b0;
      end else if (mode == `TPM_MODE_CAPCMP && act_edge) begin
        started <= 1'b1; // see R08
      end
      if (cap_now) begin
        capture_val <= count; // see R03
      end
      if (at_reload) begin
        count <= 16'h0001;
      end else if (run) begin
        count <= count + 16'h0001;
      end
    end
  end
  // ****************************************
  // output level
  // ****************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      out_lvl <= 1'b0;
    end else if (!en) begin
      out_lvl <= 1'b0;
      if (mode == `TPM_MODE_CMP) begin
        out_lvl <= pol; // see R04
      end
    end else if (mode == `TPM_MODE_CMP) begin
      if (at_reload) begin
        out_lvl <= ~out_lvl; // see R05
      end
    end else if (at_reload) begin
      out_lvl <= 1'b0; // see R01
    end else if (at_match) begin
      out_lvl <= 1'b1; // see R02
    end
  end
  // out_lvl 1 means active phase (after match)
  wire dual = (mode == `TPM_MODE_PWM2);
  wire main_act;
  wire comp_act;
  tpm_delay #(.W(8)) u_dly_main (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req(en & dual & out_lvl),
    .delay(pwm_deadband_delay),
    .active(main_act)
  );
  tpm_delay #(.W(8)) u_dly_comp (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req(en & dual & ~out_lvl),
    .delay(pwm_deadband_delay),
    .active(comp_act)
  );
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      timer_out <= 1'b0;
      timer_out_n <= 1'b1;
    end else if (mode == `TPM_MODE_CMP) begin
      timer_out <= out_lvl; // see R05
      timer_out_n <= ~out_lvl;
    end else if (dual) begin
      // both pins sit inactive until their delay expires
      if (!en) begin
        timer_out <= pol; // see R10
        timer_out_n <= ~pol; // see R11
      end else begin
        timer_out <= main_act ? ~pol : pol; // see R12
        timer_out_n <= comp_act ? ~pol : pol; // see R12
      end
    end else begin
      timer_out <= out_lvl ^ pol; // see R01
      timer_out_n <= ~(out_lvl ^ pol); // see R02
    end
  end
  // ****************************************
  // interrupt status
  // ****************************************
  wire [3:0] events;
  assign events[`TPM_ST_RELOAD] = at_reload;
  assign events[`TPM_ST_CAPT] = cap_now;
  assign events[`TPM_ST_GATE] =
    en & (mode == `TPM_MODE_GATED) & gate_end; // see R07
  assign events[`TPM_ST_MATCH] = at_match;
  // writes commit at the edge where the answer is sampled
  wire wr_hit = avs_write & acked;
  wire [3:0] w1c = (wr_hit && avs_address == `TPM_ADDR_STATUS &&
    avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      status <= 4'h0;
      irq <= 1'b0;
    end else begin
      // a set in the same cycle beats the clear
      status <= (status & ~w1c) | events;
      irq <= |(((status & ~w1c) | events) & mask);
    end
  end
  // ****************************************
  // avalon slave: one wait cycle per access
  // ****************************************
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      acked <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      timer_control_zero <= `TPM_CTRL_RST;
      reload_val <= `TPM_RELOAD_RST;
      match_val <= 16'h0000;
      mask <= 4'h0;
    end else begin
      acked <= (avs_read | avs_write) & ~acked;
      avs_waitrequest <= ~((avs_read | avs_write) & ~acked);
      if (avs_read && !acked) begin
        case (avs_address)
          `TPM_ADDR_CTRL: avs_readdata <= timer_control_zero;
          `TPM_ADDR_RELOAD: avs_readdata <= {16'h0000, reload_val};
          `TPM_ADDR_MATCH: avs_readdata <= {16'h0000, match_val};
          `TPM_ADDR_COUNT: avs_readdata <= {16'h0000, count};
          `TPM_ADDR_CAPTURE: avs_readdata <= {16'h0000, capture_val};
          `TPM_ADDR_STATUS: avs_readdata <= {28'h0000000, status};
          `TPM_ADDR_MASK: avs_readdata <= {28'h0000000, mask};
          `TPM_ADDR_PINS: avs_readdata <=
            {29'h00000000, in_lvl, timer_out_n, timer_out};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (wr_hit) begin
        case (avs_address)
          `TPM_ADDR_CTRL: begin
            if (avs_byteenable[0])
              timer_control_zero[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              timer_control_zero[15:8] <= avs_writedata[15:8];
          end
          `TPM_ADDR_RELOAD: begin
            if (avs_byteenable[0]) reload_val[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              reload_val[15:8] <= avs_writedata[15:8];
          end
          `TPM_ADDR_MATCH: begin
            if (avs_byteenable[0]) match_val[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) match_val[15:8] <= avs_writedata[15:8];
          end
          `TPM_ADDR_MASK: begin
            if (avs_byteenable[0]) mask <= avs_writedata[3:0];
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// ===== verification/tpm_monitor.sv
`timescale 1ns/10ps
// ****************************************
// bus and pin checker
// ****************************************
module tpm_monitor (
  input wire ref_clk, // system clock
  input wire reset_n, // sync reset, low
  input wire [3:0] avs_address, // word address
  input wire avs_read, // read strobe
  input wire avs_write, // write strobe
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // stall
  input wire timer_out, // timer output pin
  input wire timer_out_n, // complement pin
  input wire irq // level interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire req = avs_read || avs_write;
  reset_vals_a: assert property ($past(!reset_n) |->
    avs_waitrequest && !irq && !timer_out && timer_out_n)
    else $error("outputs not at reset values");
  one_cycle_ack_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without request");
  ack_bound_a: assert property (req && avs_waitrequest |->
    ##[0:2] !avs_waitrequest) else $error("request not answered");
  read_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[3] |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (!avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000) else $error("upper half not zero");
  irq_clear_a: assert property ($fell(irq) |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt dropped without write");
  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(irq));
endmodule
bind tpm_top tpm_monitor u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_out(timer_out), .timer_out_n(timer_out_n), .irq(irq));

// ===== verification/tpm_pin_model.sv
`timescale 1ns/10ps
// ****************************************
// external source on the timer input pin
// ****************************************
module tpm_pin_model (
  input wire want, // level asked by the bench
  output reg timer_in // timer input pin
);
  initial timer_in = 1'b0;
  // moves off the clock edge, as a real async source would
  always @(want) timer_in <= #1.3 want;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
`include "tpm_defs.vh"
module testbench;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire timer_in;
  wire timer_out;
  wire timer_out_n;
  wire irq;
  reg pin_want = 1'b0;
  integer fail_count = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  integer w;
  integer m;
  reg [2:0] md;
  reg [63:0] notes[$];
  reg [63:0] nt;
  always #2.5 ref_clk = ~ref_clk;
  tpm_top dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_in(timer_in), .timer_out(timer_out),
    .timer_out_n(timer_out_n), .irq(irq));
  tpm_pin_model pin (.want(pin_want), .timer_in(timer_in));
  // ****************************************
  // shared tasks
  // ****************************************
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task bus(input wr, input [3:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp, input [31:0] msk);
    begin
      notes.push_back({msk, exp});
      bus(1'b0, a, 32'h0);
    end
  endtask
  task ctl(input [2:0] mo, input pol, input en, input [7:0] dly);
    bus(1'b1, `TPM_ADDR_CTRL, {16'h0000, dly, 3'h0, mo, pol, en});
  endtask
  task pin_to(input v);
    begin
      pin_want <= v;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  function pv(input s);
    pv = s ? timer_out_n : timer_out;
  endfunction
  task meas(input s, input v, input [31:0] exp);
    begin
      w = 0;
      while (pv(s) === v) @(posedge ref_clk);
      while (pv(s) !== v) @(posedge ref_clk);
      // the pulse after a mode change may be cut short
      while (pv(s) === v) @(posedge ref_clk);
      while (pv(s) !== v) @(posedge ref_clk);
      while (pv(s) === v) begin
        w = w + 1;
        @(posedge ref_clk);
      end
      check("width", w, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    if (reset_n && avs_read && avs_waitrequest === 1'b0) begin
      nt = notes.size() ? notes.pop_front() : 64'h0;
      check("rd", avs_readdata & nt[63:32], nt[31:0]);
    end
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    w = $urandom(22341);
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`TPM_ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`TPM_ADDR_RELOAD, 32'hFFFF, 32'hFFFFFFFF);
    rd(4'h9, 32'h0, 32'hFFFFFFFF);
    for (i = 0; i < 6; i = i + 1) begin
      md = i < 2 ? `TPM_MODE_PWM1 : i < 4 ? `TPM_MODE_CMP : `TPM_MODE_PWM2;
      ctl(md, i % 2, 1'b0, 8'h00);
      repeat (3) @(posedge ref_clk);
      check("out", timer_out, i % 2);
      if (md != `TPM_MODE_PWM1)
        check("out_n", timer_out_n, 1 - i % 2);
      rd(`TPM_ADDR_PINS, i % 2, 32'h00000005);
    end
    bus(1'b1, `TPM_ADDR_RELOAD, 32'h0000000C);
    for (i = 0; i < 2; i = i + 1) begin
      m = 2 + $urandom % 8;
      bus(1'b1, `TPM_ADDR_MATCH, m);
      ctl(`TPM_MODE_PWM1, i, 1'b1, 8'h00);
      meas(1'b0, !i, 12 - m);
    end
    ctl(`TPM_MODE_CMP, 1'b0, 1'b1, 8'h00);
    meas(1'b0, 1'b1, 12);
    bus(1'b1, `TPM_ADDR_RELOAD, 32'h00000014);
    bus(1'b1, `TPM_ADDR_MATCH, 32'h00000008);
    for (i = 0; i < 2; i = i + 1) begin
      ctl(`TPM_MODE_PWM2, i, 1'b1, 8'h03);
      meas(1'b0, !i, 20 - 8 - 3);
      meas(1'b1, !i, 8 - 3);
    end
    for (i = 0; i < 4; i = i + 1) begin
      md = i < 2 ? `TPM_MODE_CAPT : `TPM_MODE_CAPCMP;
      pin_to(i % 2);
      // a fresh enable re-arms the start edge
      ctl(md, i % 2, 1'b0, 8'h00);
      ctl(md, i % 2, 1'b1, 8'h00);
      bus(1'b1, `TPM_ADDR_STATUS, 32'h0000000F);
      pin_to(1 - i % 2);
      rd(`TPM_ADDR_STATUS, i < 2 ? 32'h2 : 32'h0, 32'h2);
      bus(1'b1, `TPM_ADDR_STATUS, 32'h0000000F);
      pin_to(i % 2);
      rd(`TPM_ADDR_STATUS, 32'h0, 32'h2);
      pin_to(1 - i % 2);
      rd(`TPM_ADDR_STATUS, 32'h2, 32'h2);
    end
    bus(1'b1, `TPM_ADDR_RELOAD, 32'h00000004);
    for (i = 0; i < 2; i = i + 1) begin
      pin_to(i);
      bus(1'b1, `TPM_ADDR_MASK, 32'h00000004);
      ctl(`TPM_MODE_GATED, i, 1'b1, 8'h00);
      bus(1'b1, `TPM_ADDR_STATUS, 32'h0000000F);
      rd(`TPM_ADDR_STATUS, 32'h0, 32'h5);
      pin_to(!i);
      bus(1'b1, `TPM_ADDR_STATUS, 32'h0000000F);
      // let at least one full reload period pass
      repeat (4) @(posedge ref_clk);
      rd(`TPM_ADDR_STATUS, 32'h1, 32'h5);
      pin_to(i);
      rd(`TPM_ADDR_STATUS, 32'h4, 32'h4);
      check("irq", irq, 1);
      bus(1'b1, `TPM_ADDR_MASK, 32'h00000000);
      repeat (3) @(posedge ref_clk);
      check("irq", irq, 0);
      bus(1'b1, `TPM_ADDR_MASK, 32'h00000004);
      bus(1'b1, `TPM_ADDR_STATUS, 32'h00000004);
      repeat (3) @(posedge ref_clk);
      check("irq", irq, 0);
    end
    final_report;
  end
endmodule
